// >>> rtl/cbm_bus_master.sv
// processor bus master: hold handshake and single non-burst cycle
`timescale 1ns/1ps
module cbm_bus_master #(
	parameter int AW = cbm_pkg::CBM_ADDR_W,
	parameter int DW = cbm_pkg::CBM_DATA_W
) (
	input wire logic i_clk,
	input wire logic i_rst,
	// internal requester side
	input wire logic i_req,
	input wire logic i_req_write,
	input wire logic [AW-1:0] i_req_addr,
	input wire logic [DW-1:0] i_req_wdata,
	output logic o_req_done,
	output logic [DW-1:0] o_rdata,
	// arbitration pins
	input wire logic i_hold,
	output logic o_bus_request_out,
	output logic o_yield_acknowledge,
	// cycle pins
	output logic o_address_strobe_n,
	output logic o_last_transfer_n,
	output logic o_parity_check_out_n,
	input wire logic i_ready_n,
	input wire logic i_burst_ready_n,
	output logic [AW-1:0] o_addr,
	output logic o_write,
	output logic o_addr_oe,
	output logic [DW-1:0] o_data_out,
	output logic o_data_oe,
	input wire logic [DW-1:0] i_data_in,
	input wire logic [DW/8-1:0] i_data_par
);
	localparam int PW = DW / 8;
	localparam int SW = 3 + DW + PW;

	// all checks below run on the bus clock and sleep during reset
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);

	// ----------------------------------------
	// parity helper
	// ----------------------------------------
	// high per lane when data plus parity bit is odd
	function automatic logic [PW-1:0] par_err(input logic [DW-1:0] d, input logic [PW-1:0] p);
		logic [PW-1:0] e;
		e = '0;
		for (int i = 0; i < PW; i++) begin
			e[i] = ^{d[i*8 +: 8], p[i]};
		end
		return e;
	endfunction : par_err

	// ----------------------------------------
	// pin input synchronisers
	// ----------------------------------------
	cbm_sync_if #(.W(SW)) pin_s ();
	// ready lanes go in inverted, so the cleared synchroniser reads as not ready
	assign pin_s.raw = {i_hold, !i_ready_n, !i_burst_ready_n, i_data_par, i_data_in};

	cbm_sync #(.W(SW)) u_sync (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.s(pin_s)
	);

	logic hold_s;
	logic rdy_s;
	logic burst_ready_s;
	logic rdy_n_s;
	logic burst_ready_n_s;
	logic [PW-1:0] par_s;
	logic [DW-1:0] data_s;
	assign {hold_s, rdy_s, burst_ready_s, par_s, data_s} = pin_s.sync;
	// back to active-low view of the synchronised ready pins
	assign rdy_n_s = !rdy_s;
	assign burst_ready_n_s = !burst_ready_s;

	// ----------------------------------------
	// sequencer state and registered pins
	// ----------------------------------------
	cbm_pkg::cbm_state_t state_q, state_d;
	logic ads_n_q, ads_n_d;
	logic last_n_q, last_n_d;
	logic parity_check_out_n_q, parity_check_out_n_d;
	logic yield_q, yield_d;
	logic bus_request_out_q, bus_request_out_d;
	logic done_q, done_d;
	logic wr_q, wr_d;
	logic aoe_q, aoe_d;
	logic doe_q, doe_d;
	logic [AW-1:0] addr_q, addr_d;
	logic [DW-1:0] wdata_q, wdata_d;
	logic [DW-1:0] rdata_q, rdata_d;
	logic term;
	logic start;

	// either ready ends the cycle; with both, it is a non-burst end
	assign term = !rdy_n_s || !burst_ready_n_s; // RL19
	// may take the bus only with hold and acknowledge both low
	assign start = i_req && !done_q && !hold_s && !yield_q; // RL2

	// next state and next pin values
	always_comb begin
		state_d = state_q;
		wr_d = wr_q;
		addr_d = addr_q;
		wdata_d = wdata_q;
		rdata_d = rdata_q;
		done_d = 1'b0;
		parity_check_out_n_d = 1'b1;
		unique case (state_q)
			cbm_pkg::CBM_IDLE: begin
				if (hold_s) begin
					state_d = cbm_pkg::CBM_HELD; // RL3
				end else if (start) begin
					state_d = cbm_pkg::CBM_T1; // RL12
					wr_d = i_req_write;
					addr_d = i_req_addr;
					wdata_d = i_req_wdata;
				end
			end
			cbm_pkg::CBM_T1: begin
				state_d = cbm_pkg::CBM_T2; // RL13
			end
			cbm_pkg::CBM_T2: begin
				// wait states repeat the second state
				if (term) begin
					state_d = hold_s ? cbm_pkg::CBM_HELD : cbm_pkg::CBM_IDLE; // RL11
					done_d = 1'b1;
					if (!wr_q) begin
						rdata_d = data_s;
						parity_check_out_n_d = !(|par_err(data_s, par_s)); // RL16
					end
				end
			end
			cbm_pkg::CBM_HELD: begin
				if (!hold_s) begin
					state_d = cbm_pkg::CBM_IDLE;
				end
			end
		endcase
		ads_n_d = !(state_d == cbm_pkg::CBM_T1); // RL12
		last_n_d = !(state_d == cbm_pkg::CBM_T2); // RL15
		yield_d = (state_d == cbm_pkg::CBM_HELD); // RL3
		aoe_d = (state_d != cbm_pkg::CBM_HELD); // RL4
		doe_d = wr_d && (state_d == cbm_pkg::CBM_T1 || state_d == cbm_pkg::CBM_T2); // RL4
		// a request already answered is not pending any more
		bus_request_out_d = (i_req && !done_d && !done_q) || state_d == cbm_pkg::CBM_T1 ||
			state_d == cbm_pkg::CBM_T2; // RL1
	end

	// register everything; reset leaves the bus idle
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state_q <= cbm_pkg::CBM_IDLE; // RL20
			ads_n_q <= cbm_pkg::CBM_RST_STROBE_N; // RL20
			last_n_q <= cbm_pkg::CBM_RST_LAST_N;
			parity_check_out_n_q <= cbm_pkg::CBM_RST_PARITY_CHECK_OUT_N;
			yield_q <= cbm_pkg::CBM_RST_YIELD; // RL20
			bus_request_out_q <= cbm_pkg::CBM_RST_BUS_REQUEST_OUT;
			done_q <= 1'b0;
			wr_q <= 1'b0;
			aoe_q <= 1'b1;
			doe_q <= 1'b0;
			addr_q <= '0;
			wdata_q <= '0;
			rdata_q <= '0;
		end else begin
			state_q <= state_d;
			ads_n_q <= ads_n_d;
			last_n_q <= last_n_d;
			parity_check_out_n_q <= parity_check_out_n_d;
			yield_q <= yield_d;
			bus_request_out_q <= bus_request_out_d;
			done_q <= done_d;
			wr_q <= wr_d;
			aoe_q <= aoe_d;
			doe_q <= doe_d;
			addr_q <= addr_d;
			wdata_q <= wdata_d;
			rdata_q <= rdata_d;
		end
	end

	// outputs straight from flip-flops
	assign o_req_done = done_q;
	assign o_rdata = rdata_q;
	assign o_bus_request_out = bus_request_out_q;
	assign o_yield_acknowledge = yield_q;
	assign o_address_strobe_n = ads_n_q;
	assign o_last_transfer_n = last_n_q;
	assign o_parity_check_out_n = parity_check_out_n_q;
	assign o_addr = addr_q;
	assign o_write = wr_q;
	assign o_addr_oe = aoe_q;
	assign o_data_out = wdata_q;
	assign o_data_oe = doe_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	chk_bus_request_out_follows_req: assert property (i_req && !done_q && !done_d |=> o_bus_request_out) // RL1
		else $error("bus request not raised for pending request");
	chk_bus_request_out_in_cycle: assert property (state_q == cbm_pkg::CBM_T1 || state_q == cbm_pkg::CBM_T2 |-> o_bus_request_out) // RL1
		else $error("bus request low during a cycle");
	chk_no_start_held: assert property ($fell(o_address_strobe_n) |-> !$past(hold_s) && !$past(yield_q)) // RL2
		else $error("cycle started while hold or acknowledge active");
	chk_strobe_needs_own: assert property (!o_address_strobe_n |-> o_addr_oe && !o_yield_acknowledge) // RL2
		else $error("strobe without bus ownership");
	chk_doe_write_only: assert property (o_data_oe |-> o_write && o_addr_oe) // RL4
		else $error("data driven outside a write cycle");
	chk_last_only_t2: assert property (!o_last_transfer_n |-> state_q == cbm_pkg::CBM_T2) // RL15
		else $error("last transfer outside second bus state");
	chk_hold_ack_idle: assert property (state_q == cbm_pkg::CBM_IDLE && hold_s |=> o_yield_acknowledge) // RL3
		else $error("hold not acknowledged from idle");
	chk_float_when_held: assert property (o_yield_acknowledge |-> !o_addr_oe && !o_data_oe) // RL4
		else $error("pins driven while bus yielded");
	chk_strobe_one_clk: assert property ($fell(o_address_strobe_n) |=> o_address_strobe_n && !o_last_transfer_n) // RL12
		else $error("strobe not single clock or last transfer late");
	chk_ready_ignored_t1: assert property (state_q == cbm_pkg::CBM_T1 |=> state_q == cbm_pkg::CBM_T2 && !o_req_done) // RL13
		else $error("cycle ended in first clock");
	chk_end_on_ready: assert property (state_q == cbm_pkg::CBM_T2 && !rdy_n_s |=> o_req_done && o_last_transfer_n) // RL11
		else $error("ready did not end cycle");
	chk_wait_holds: assert property (state_q == cbm_pkg::CBM_T2 && rdy_n_s && burst_ready_n_s |=> state_q == cbm_pkg::CBM_T2 && !o_req_done) // RL19
		else $error("cycle ended without ready");
	chk_parity_check_out_timing: assert property (!o_parity_check_out_n |-> $past(state_q) == cbm_pkg::CBM_T2 && o_req_done && !o_write) // RL16
		else $error("parity check not one clock after read end");
endmodule : cbm_bus_master

// >>> rtl/cbm_pkg.sv
// constants and types for the bus master handshake block
//
// Functional notes
// RL1: request bus while activity is pending
// RL2: start cycles only without hold or acknowledge
// RL3: acknowledge hold once bus can be released
// RL4: float address, data, status when not owner (here only address and data float; the status pins have no enable)
// RL5: secondary master drops hold when finished
// RL6: arbiter grants exactly one master
// RL7: arbiter serves requests one at a time
// RL8: arbiter samples request or hold outputs
// RL9: arbiter grants only after all acknowledged
// RL10: owner keeps bus until another requests
// RL11: cycle is strobe clock plus ready clock
// RL12: strobe with valid address in first clock
// RL13: sample ready in second clock, not first
// RL14: system readies only with valid data
// RL15: last transfer low in second bus state
// RL16: parity check output one clock after read
// RL17: system holds ready off for wait states
// RL18: burst ready off whenever ready is off
// RL19: both readies means non-burst termination
// RL20: reset leaves bus idle, no acknowledge
package cbm_pkg;
	// ----------------------------------------
	// bus sequencer states
	// ----------------------------------------
	typedef enum logic [1:0] {
		CBM_IDLE,
		CBM_T1,
		CBM_T2,
		CBM_HELD
	} cbm_state_t;

	// ----------------------------------------
	// widths and values after reset
	// ----------------------------------------
	localparam int CBM_ADDR_W = 32;
	localparam int CBM_DATA_W = 32;
	localparam int CBM_SYNC_STAGES = 2;
	localparam logic CBM_RST_STROBE_N = 1'h1;
	localparam logic CBM_RST_LAST_N = 1'h1;
	localparam logic CBM_RST_PARITY_CHECK_OUT_N = 1'h1;
	localparam logic CBM_RST_YIELD = 1'h0;
	localparam logic CBM_RST_BUS_REQUEST_OUT = 1'h0;
endpackage : cbm_pkg

// >>> rtl/cbm_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module cbm_sync #(
	parameter int W = 1
) (
	input wire logic i_clk,
	input wire logic i_rst,
	cbm_sync_if.dst s
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	// first stage feeds only the second
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= s.raw;
			sync_q <= meta_q;
		end
	end

	assign s.sync = sync_q;
endmodule : cbm_sync

// >>> rtl/cbm_sync_if.sv
// raw pin inputs and their synchronised copies
`timescale 1ns/1ps
interface cbm_sync_if #(
	parameter int W = 1
);
	logic [W-1:0] raw;
	logic [W-1:0] sync;
	modport src (output raw, input sync);
	modport dst (input raw, output sync);
endinterface : cbm_sync_if

// >>> test/cbm_far_side.sv
// far side model: memory responder with wait states and parity
`timescale 1ns/1ps
module cbm_far_side #(
	parameter logic [31:0] KEY = 32'hC3C3_5A5A
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_address_strobe_n,
	input wire logic i_req_done,
	input wire logic [31:0] i_addr,
	input wire logic [31:0] i_data_out,
	input wire logic [3:0] i_waits,
	input wire logic i_both,
	input wire logic i_bad,
	output logic o_ready_n,
	output logic o_burst_ready_n,
	output logic [31:0] o_data_in,
	output logic [3:0] o_data_par,
	output logic [31:0] o_wdata_q
);
	logic act_q;
	logic [3:0] cnt_q;
	logic [31:0] rd;
	// ----------------------------------------
	// ready sequencing
	// ----------------------------------------
	// ready after the chosen waits, held until the cycle ends
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			act_q <= 1'h0;
			cnt_q <= 4'h0;
			o_ready_n <= 1'h1;
			o_wdata_q <= 32'h0;
		end else if (i_req_done) begin
			act_q <= 1'h0;
			o_ready_n <= 1'h1;
		end else if (!i_address_strobe_n) begin
			act_q <= 1'h1;
			cnt_q <= 4'h0;
		end else if (act_q && o_ready_n) begin
			if (cnt_q == i_waits) begin
				o_ready_n <= 1'h0;
				o_wdata_q <= i_data_out;
			end else begin
				cnt_q <= cnt_q + 4'h1;
			end
		end
	end
	// data valid only with ready, inverted otherwise
	assign rd = i_addr ^ KEY;
	assign o_data_in = o_ready_n ? ~rd : rd;
	assign o_burst_ready_n = o_ready_n | ~i_both;
	assign o_data_par = {^rd[31:24], ^rd[23:16], ^rd[15:8], ^rd[7:0] ^ i_bad};
endmodule : cbm_far_side

// >>> test/test_cbm_bus_master_handshake.sv
// testbench for the bus master handshake block
`timescale 1ns/1ps
module test_cbm_bus_master_handshake;
	localparam logic [31:0] KEY = 32'hC3C3_5A5A;
	logic i_clk, i_rst, i_req, i_req_write, i_hold, both, bad;
	logic [31:0] i_req_addr, i_req_wdata, o_rdata, o_addr, o_data_out, i_data_in, wseen;
	logic o_req_done, o_bus_request_out, o_yield_acknowledge, o_address_strobe_n;
	logic o_last_transfer_n, o_parity_check_out_n, i_ready_n, i_burst_ready_n;
	logic o_write, o_addr_oe, o_data_oe;
	logic [3:0] i_data_par, waits;
	int n_mismatch = 0;
	int num_checks = 0;
	cbm_bus_master DUT (.i_clk, .i_rst, .i_req, .i_req_write, .i_req_addr, .i_req_wdata,
		.o_req_done, .o_rdata, .i_hold, .o_bus_request_out, .o_yield_acknowledge,
		.o_address_strobe_n, .o_last_transfer_n, .o_parity_check_out_n, .i_ready_n,
		.i_burst_ready_n, .o_addr, .o_write, .o_addr_oe, .o_data_out, .o_data_oe,
		.i_data_in, .i_data_par);
	cbm_far_side #(.KEY(KEY)) far (.i_clk(i_clk), .i_rst(i_rst),
		.i_address_strobe_n(o_address_strobe_n), .i_req_done(o_req_done), .i_addr(o_addr),
		.i_data_out(o_data_out), .i_waits(waits), .i_both(both), .i_bad(bad),
		.o_ready_n(i_ready_n), .o_burst_ready_n(i_burst_ready_n), .o_data_in(i_data_in),
		.o_data_par(i_data_par), .o_wdata_q(wseen));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	always #2 i_clk = ~i_clk;
	task automatic print_verdict();
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic bound_ok(input logic hit);
		if (!hit) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, hit, 1'h1);
			print_verdict();
		end
	endtask : bound_ok
	// one single cycle, counting strobe and last-transfer clocks
	task automatic do_cycle(input logic wr, input logic [31:0] a, input logic [31:0] wd,
		input logic [3:0] w, input logic bo, input logic bd);
		int n, ns, nl;
		n = 0;
		ns = 0;
		nl = 0;
		@(posedge i_clk);
		waits <= w;
		both <= bo;
		bad <= bd;
		i_req <= 1'h1;
		i_req_write <= wr;
		i_req_addr <= a;
		i_req_wdata <= wd;
		do begin
			@(posedge i_clk);
			#1;
			n++;
			if (!o_address_strobe_n) begin
				chk(o_addr, a);
				chk(o_bus_request_out, 1'h1);
				chk({o_write, o_data_oe, o_addr_oe}, {wr, wr, 1'h1});
			end
			ns += !o_address_strobe_n;
			nl += !o_last_transfer_n;
		end while (o_req_done !== 1'h1 && n < 80);
		bound_ok(n < 80);
		chk(ns, 1);
		// far side registers ready, two synchroniser clocks, then the end edge
		chk(nl, w + 4);
		chk(o_parity_check_out_n, wr | !bd);
		chk(wr ? wseen : o_rdata, wr ? wd : a ^ KEY);
		@(posedge i_clk) i_req <= 1'h0;
	endtask : do_cycle
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		#1 chk({o_address_strobe_n, o_yield_acknowledge, o_bus_request_out}, 3'h4);
	endtask : t_reset
	task automatic t_reads();
		do_cycle(1'h0, 32'h0000_1000, 32'h0, 4'h0, 1'h0, 1'h0);
		do_cycle(1'h0, 32'hFFFF_FFFC, 32'h0, 4'h3, 1'h0, 1'h0);
		do_cycle(1'h0, 32'h0000_0004, 32'h0, 4'h1, 1'h0, 1'h1);
	endtask : t_reads
	task automatic t_write();
		do_cycle(1'h1, 32'h0000_2000, 32'hDEAD_BEEF, 4'h2, 1'h0, 1'h0);
	endtask : t_write
	task automatic t_both();
		do_cycle(1'h0, 32'h0000_3000, 32'h0, 4'h0, 1'h1, 1'h0);
	endtask : t_both
	// reset in mid-run while the bus is yielded
	task automatic t_reset_mid();
		int k;
		@(posedge i_clk) i_hold <= 1'h1;
		for (k = 0; k < 10 && o_yield_acknowledge !== 1'h1; k++) @(posedge i_clk) #1;
		bound_ok(k < 10);
		@(posedge i_clk) i_rst <= 1'h1;
		#1 chk({o_yield_acknowledge, o_addr_oe, o_address_strobe_n}, 3'h3);
		@(posedge i_clk) i_hold <= 1'h0;
		repeat (2) @(posedge i_clk);
		i_rst <= 1'h0;
		t_reset();
	endtask : t_reset_mid
	task automatic t_hold();
		int k, ns;
		@(posedge i_clk) i_hold <= 1'h1;
		for (k = 0; k < 10 && o_yield_acknowledge !== 1'h1; k++) @(posedge i_clk) #1;
		bound_ok(k < 10);
		chk(o_addr_oe, 1'h0);
		@(posedge i_clk);
		i_req <= 1'h1;
		i_req_write <= 1'h0;
		i_req_addr <= 32'h0000_0044;
		ns = 0;
		repeat (8) begin
			@(posedge i_clk);
			#1;
			ns += !o_address_strobe_n;
		end
		chk(ns, 0);
		chk(o_bus_request_out, 1'h1);
		@(posedge i_clk) i_hold <= 1'h0;
		do_cycle(1'h0, 32'h0000_0044, 32'h0, 4'h0, 1'h0, 1'h0);
		chk({o_yield_acknowledge, o_addr_oe}, 2'h1);
	endtask : t_hold
	initial begin
		{i_clk, i_req, i_req_write, i_hold, both, bad, waits} = '0;
		{i_req_addr, i_req_wdata} = '0;
		i_rst = 1'h1;
		repeat (4) @(posedge i_clk);
		i_rst <= 1'h0;
		t_reset();
		t_reads();
		t_reset_mid();
		t_write();
		t_both();
		t_hold();
		print_verdict();
	end
endmodule : test_cbm_bus_master_handshake
